// ### seis_regs.svh
// constants of the serial eeprom two-wire slave
`ifndef SEIS_REGS_SVH
`define SEIS_REGS_SVH
`define SEIS_DEV_CODE   4'ha
`define SEIS_MEM_BYTES  8192
`define SEIS_PAGE_BYTES 32
`define SEIS_ERASED     8'hff
`define SEIS_PROG_US    4000
`define SEIS_CLK_NS     10
`define SEIS_BIT_FULL   4'h8
`define SEIS_BIT_LAST   4'h7
`define SEIS_IDX_DEV    3'h0
`define SEIS_IDX_AHI    3'h1
`define SEIS_IDX_ALO    3'h2
`define SEIS_IDX_FIRST  3'h3
`define SEIS_IDX_MORE   3'h4
`endif

// ### seis_pkg.sv
// types of the serial eeprom two-wire slave
package seis_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_MACK = 5'h10
	} seis_state_t;
endpackage

// ### seis_top.sv
// two-wire slave front end and storage of a byte-addressed eeprom
//
// Summary of operation
// - power-on reset input returns all logic to idle standby state
// - sample data on clock rise, change output on fall, pull low only
// - start is data fall, stop is data rise, both while clock high
// - address byte: code 1010, three strap bits, direction; full match
// - ninth clock: transmitter releases, receiver pulls low to acknowledge
// - byte write: address, two address bytes, data, stop; all acked
// - stop after write starts programming; no acknowledge while busy
// - up to one page of bytes buffered from the given address
// - page part fixed, offset steps and wraps, later bytes overwrite
// - stop after page load commits buffered bytes, one byte per cycle
// - protect input high refuses all writes, low has no effect
// - protect sampled before first data byte; if high, nack and drop
// - memory starts erased, every byte all ones
// - read direction: ack then send byte at current address
// - selective read: address load, repeated start, read from there
// - sequential read while master acks, address wraps at the end
`timescale 1ns/1ps
`include "seis_regs.svh"

module seis_top #(
	parameter int MEM_BYTES   = `SEIS_MEM_BYTES,
	parameter int PAGE_BYTES  = `SEIS_PAGE_BYTES,
	parameter int PROG_CYCLES = `SEIS_PROG_US * 1000 / `SEIS_CLK_NS
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic select_strap_bit0,
	input  wire logic select_strap_bit1,
	input  wire logic select_strap_bit2,
	input  wire logic wp_i,
	output logic      sda_o,
	output logic      sda_oe,
	output logic      prog_busy
);
	import seis_pkg::*;

	localparam int AW = $clog2(MEM_BYTES);
	localparam int PW = $clog2(PAGE_BYTES);
	localparam int CW = $clog2(PROG_CYCLES + 1);
	localparam logic [CW-1:0] PAGE_C = CW'(PAGE_BYTES);
	localparam logic [CW-1:0] LAST_C = CW'(PROG_CYCLES - 1);

	// shapes the logic cannot serve
	if (MEM_BYTES != 2 ** AW || PAGE_BYTES != 2 ** PW || AW > 16 ||
	    PAGE_BYTES >= MEM_BYTES || PROG_CYCLES < PAGE_BYTES) begin : g_bad
		$error("seis_top: unsupported parameter values");
	end

	logic [5:0]       in_m_q, in_s_q;
	logic             scl_p_q, sda_p_q;
	logic             scl, sda, wp;
	logic [2:0]       strap;
	logic             scl_rise, scl_fall, start_ev, stop_ev;
	seis_state_t      st_q, st_d;
	logic [3:0]       bit_q, bit_d;
	logic [2:0]       idx_q, idx_d;
	logic [7:0]       sh_q, sh_d, ahi_q, ahi_d;
	logic             rw_q, rw_d, mack_q, mack_d, oe_q, oe_d;
	logic             wpl_q, wpl_d, pend_q, pend_d, busy_q, busy_d;
	logic [AW-1:0]    addr_q, addr_d;
	logic [CW-1:0]    cnt_q, cnt_d;
	logic [AW-PW-1:0] cpage_q, cpage_d;
	logic [PAGE_BYTES-1:0] vld_q, vld_d;
	logic [7:0]       buf_q [PAGE_BYTES];
	logic [7:0]       mem_q [MEM_BYTES];
	logic             buf_we, mem_we, load_tx, match;
	logic [PW-1:0]    off;
	logic [AW-1:0]    mem_wa;
	logic [7:0]       mem_wd, rd;

	// pins pass two flops; only the second stage is looked at
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			in_m_q  <= 6'h3f;
			in_s_q  <= 6'h3f;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			in_m_q  <= {wp_i, select_strap_bit2, select_strap_bit1,
			            select_strap_bit0, sda_i, scl_i};
			in_s_q  <= in_m_q;
			scl_p_q <= scl;
			sda_p_q <= sda;
		end
	end

	// bus events found from the synchronised lines
	assign scl      = in_s_q[0];
	assign sda      = in_s_q[1];
	assign strap    = in_s_q[4:2];
	assign wp       = in_s_q[5];
	assign scl_rise = scl & ~scl_p_q;
	assign scl_fall = ~scl & scl_p_q;
	assign start_ev = scl & scl_p_q & sda_p_q & ~sda;
	assign stop_ev  = scl & scl_p_q & ~sda_p_q & sda;
	assign off      = addr_q[PW-1:0];
	assign rd       = mem_q[addr_q];
	assign match    = sh_q[7:4] == `SEIS_DEV_CODE && sh_q[3:1] == strap;
	assign load_tx  = scl_fall && ((st_q == ST_ACK && rw_q) ||
	                  (st_q == ST_MACK && mack_q));

	// protocol engine and commit engine next state
	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		idx_d = idx_q;
		sh_d = sh_q;
		ahi_d = ahi_q;
		rw_d = rw_q;
		mack_d = mack_q;
		oe_d = oe_q;
		wpl_d = wpl_q;
		pend_d = pend_q;
		busy_d = busy_q;
		addr_d = addr_q;
		cnt_d = cnt_q;
		cpage_d = cpage_q;
		vld_d = vld_q;
		buf_we = 1'b0;
		mem_we = 1'b0;
		mem_wa = {cpage_q, cnt_q[PW-1:0]};
		mem_wd = buf_q[cnt_q[PW-1:0]];
		// one buffered byte per cycle, then wait out the rest
		if (busy_q) begin
			mem_we = cnt_q < PAGE_C && vld_q[cnt_q[PW-1:0]];
			cnt_d = cnt_q + 1'b1;
			if (cnt_q == LAST_C) begin
				busy_d = 1'b0;
				vld_d = '0;
			end
		end
		case (st_q)
			ST_RX: begin
				if (scl_rise && bit_q != `SEIS_BIT_FULL) begin
					sh_d = {sh_q[6:0], sda};
					bit_d = bit_q + 1'b1;
				end else if (scl_fall && bit_q == `SEIS_BIT_FULL) begin
					st_d = ST_ACK;
					oe_d = 1'b1;
					if (idx_q != `SEIS_IDX_MORE)
						idx_d = idx_q + 1'b1;
					case (idx_q)
						`SEIS_IDX_DEV: begin
							rw_d = sh_q[0];
							if (!match || busy_q) begin
								st_d = ST_IDLE;
								oe_d = 1'b0;
							end else if (!sh_q[0]) begin
								vld_d = '0;
								pend_d = 1'b0;
							end
						end
						`SEIS_IDX_AHI: ahi_d = sh_q;
						`SEIS_IDX_ALO: addr_d = AW'({ahi_q, sh_q});
						default: begin
							if (wpl_q) begin
								st_d = ST_IDLE;
								oe_d = 1'b0;
								vld_d = '0;
								pend_d = 1'b0;
							end else begin
								buf_we = 1'b1;
								vld_d[off] = 1'b1;
								pend_d = 1'b1;
								// page part held, offset wraps
								addr_d = {addr_q[AW-1:PW], off + 1'b1};
							end
						end
					endcase
				end
			end
			ST_ACK: begin
				if (scl_fall && !rw_q) begin
					st_d = ST_RX;
					oe_d = 1'b0;
					bit_d = 4'h0;
					if (idx_q == `SEIS_IDX_FIRST)
						wpl_d = wp;
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					if (bit_q == `SEIS_BIT_LAST) begin
						st_d = ST_MACK;
						oe_d = 1'b0;
					end else begin
						sh_d = {sh_q[6:0], 1'b0};
						oe_d = ~sh_q[6];
						bit_d = bit_q + 1'b1;
					end
				end
			end
			ST_MACK: begin
				if (scl_rise)
					mack_d = ~sda;
				else if (scl_fall && !mack_q)
					st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
		// byte at current address, address steps and wraps
		if (load_tx) begin
			sh_d = rd;
			addr_d = addr_q + 1'b1;
			oe_d = ~rd[7];
			bit_d = 4'h0;
			st_d = ST_TX;
		end
		if (stop_ev) begin
			st_d = ST_IDLE;
			oe_d = 1'b0;
			if (pend_q && !busy_q) begin
				busy_d = 1'b1;
				cnt_d = '0;
				cpage_d = addr_q[AW-1:PW];
				pend_d = 1'b0;
			end
		end else if (start_ev) begin
			st_d = ST_RX;
			oe_d = 1'b0;
			bit_d = 4'h0;
			idx_d = `SEIS_IDX_DEV;
		end
	end

	// protocol and commit state; power-on reset lands in standby
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= ST_IDLE;
			bit_q <= 4'h0;
			idx_q <= `SEIS_IDX_DEV;
			sh_q <= 8'h00;
			ahi_q <= 8'h00;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			oe_q <= 1'b0;
			wpl_q <= 1'b0;
			pend_q <= 1'b0;
			busy_q <= 1'b0;
			addr_q <= '0;
			cnt_q <= '0;
			cpage_q <= '0;
			vld_q <= '0;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			idx_q <= idx_d;
			sh_q <= sh_d;
			ahi_q <= ahi_d;
			rw_q <= rw_d;
			mack_q <= mack_d;
			oe_q <= oe_d;
			wpl_q <= wpl_d;
			pend_q <= pend_d;
			busy_q <= busy_d;
			addr_q <= addr_d;
			cnt_q <= cnt_d;
			cpage_q <= cpage_d;
			vld_q <= vld_d;
		end
	end

	// page buffer entries
	for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_buf
		always_ff @(posedge clk_sys or negedge rst_b) begin
			if (!rst_b)
				buf_q[i] <= `SEIS_ERASED;
			else if (buf_we && off == PW'(i))
				buf_q[i] <= sh_q;
		end
	end

	// array entries; flop storage, so erased at every power-on
	for (genvar i = 0; i < MEM_BYTES; i++) begin : g_mem
		always_ff @(posedge clk_sys or negedge rst_b) begin
			if (!rst_b)
				mem_q[i] <= `SEIS_ERASED;
			else if (mem_we && mem_wa == AW'(i))
				mem_q[i] <= mem_wd;
		end
	end

	// open drain: the output level is always low, only the enable moves
	assign sda_o     = 1'b0;
	assign sda_oe    = oe_q;
	assign prog_busy = busy_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_commit;
		stop_ev && pend_q && !busy_q;
	endsequence
	sequence s_held;
		busy_q [*8];
	endsequence
	sequence s_dev_end;
		st_q == ST_RX && scl_fall && bit_q == `SEIS_BIT_FULL &&
		idx_q == `SEIS_IDX_DEV;
	endsequence

	AST_OE_ON_FALL: assert property ($rose(oe_q) |-> $past(scl_fall))
		else $error("data pulled low outside a clock fall");
	AST_STOP_IDLE: assert property (stop_ev |=> st_q == ST_IDLE && !oe_q)
		else $error("stop did not end the command");
	AST_NO_START: assert property (st_q == ST_IDLE && !start_ev
		|=> st_q == ST_IDLE)
		else $error("left idle without a start");
	AST_MATCH_ACK: assert property (s_dev_end ##0 (match && !busy_q)
		|=> oe_q && st_q == ST_ACK)
		else $error("matching address not acknowledged");
	AST_BUSY_NACK: assert property (s_dev_end ##0 busy_q
		|=> !oe_q ##1 !oe_q)
		else $error("acknowledged while programming");
	AST_COMMIT: assert property (s_commit |=> s_held)
		else $error("programming not started or not held");
	AST_PROG_LEN: assert property ($fell(busy_q)
		|-> $past(cnt_q) == LAST_C)
		else $error("programming time wrong");
	AST_WP_DROP: assert property (st_q == ST_RX && scl_fall &&
		wpl_q && bit_q == `SEIS_BIT_FULL && idx_q >= `SEIS_IDX_FIRST
		|=> st_q == ST_IDLE && !oe_q && !pend_q)
		else $error("protected write not refused");
	AST_PAGE_FIX: assert property (buf_we
		|=> addr_q[AW-1:PW] == $past(addr_q[AW-1:PW]) &&
		addr_q[PW-1:0] == PW'($past(addr_q[PW-1:0]) + 1'b1))
		else $error("page offset step wrong");
	AST_RD_STEP: assert property (load_tx
		|=> addr_q == AW'($past(addr_q) + 1'b1) && st_q == ST_TX)
		else $error("read address not stepped");
endmodule

// ### seis_mstr.sv
// behavioural two-wire bus master that drives the eeprom slave
`timescale 1ns/1ps

module seis_mstr (
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda_w
);
	int lo_ext;

	// idle bus: both lines released, clock stands still between frames
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		lo_ext = 0;
	end

	// one bit: data moves mid-low only, read back mid-high
	task bitx(input logic b, output logic r);
		#(36 + lo_ext) sda_m = b;
		#36 scl = 1'b1;
		#20 r = sda_w;
		#33 scl = 1'b0;
	endtask

	// also serves as repeated start when the clock is low
	task start();
		#36 sda_m = 1'b1;
		#36 scl = 1'b1;
		#36 sda_m = 1'b0;
		#36 scl = 1'b0;
	endtask

	task stop();
		#36 sda_m = 1'b0;
		#36 scl = 1'b1;
		#36 sda_m = 1'b1;
		#200;
	endtask

	// msb first, then release the line for the slave's answer
	task wbyte(input logic [7:0] d, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, a);
	endtask

	task rbyte(input logic nak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(nak, r);
	endtask
endmodule

// ### serial_eeprom_i2c_slave_tb_top.sv
// self-checking bench for the eeprom two-wire slave
`timescale 1ns/1ps
`include "seis_regs.svh"

module serial_eeprom_i2c_slave_tb_top;
	localparam int MB = 256;
	localparam int PC = 400;
	logic       clk_sys, rst_b, wp_i, sda_o, sda_oe, prog_busy;
	logic       scl, sda_m, sda_w, ack, w;
	logic [2:0] strap;
	logic [7:0] rd;
	logic [15:0] a;
	int         fails, num_checks, seed, ptr, bcnt, n;
	int         mem[MB];

	// open-drain wire with pull-up
	assign sda_w = sda_m & ~(sda_oe & ~sda_o);

	seis_mstr i_mst (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));

	seis_top #(.MEM_BYTES(MB), .PAGE_BYTES(32), .PROG_CYCLES(PC)) i_dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .scl_i(scl), .sda_i(sda_w),
		.select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]),
		.select_strap_bit2(strap[2]), .wp_i(wp_i), .sda_o(sda_o),
		.sda_oe(sda_oe), .prog_busy(prog_busy));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task conclude();
		if (fails == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task sel(input logic rw, input logic [2:0] s, output logic k);
		i_mst.start();
		i_mst.wbyte({`SEIS_DEV_CODE, s, rw}, k);
	endtask

	// upper address bits are ignored by the slave
	task setup_addr(input logic [15:0] x);
		sel(1'b0, strap, ack);
		chk(ack, 0);
		i_mst.wbyte(x[15:8], ack);
		chk(ack, 0);
		i_mst.wbyte(x[7:0], ack);
		chk(ack, 0);
		ptr = x % MB;
	endtask

	task rd_seq(input int cnt);
		sel(1'b1, strap, ack);
		chk(ack, 0);
		for (int i = 0; i < cnt; i++) begin
			i_mst.rbyte(i == cnt - 1, rd);
			chk(rd, mem[ptr]);
			ptr = (ptr + 1) % MB;
		end
		i_mst.stop();
	endtask

	// page write; offset wraps inside the page, protect drops it all
	task wr(input int cnt, input logic p);
		int base, off;
		logic [7:0] d;
		setup_addr(a);
		base = ptr - ptr % 32;
		off = ptr % 32;
		for (int i = 0; i < cnt; i++) begin
			d = 8'($random(seed));
			i_mst.wbyte(d, ack);
			chk(ack, p);
			if (!p) mem[base + off] = d;
			off = (off + 1) % 32;
		end
		i_mst.stop();
		ptr = base + off;
		repeat (10) @(negedge clk_sys);
		chk(prog_busy, !p);
		if (!p) begin
			sel(1'b0, strap, ack);
			i_mst.stop();
			chk(ack, 1);
			for (int i = 0; i < 20 && ack; i++) begin
				sel(1'b0, strap, ack);
				i_mst.stop();
			end
			chk(ack, 0);
		end
	endtask

	// programming length measured at the pin
	always @(negedge clk_sys) begin
		if (prog_busy === 1'b1)
			bcnt++;
		else if (bcnt > 0) begin
			chk(bcnt, PC);
			bcnt = 0;
		end
	end

	initial begin
		#800us;
		fails++;
		conclude();
	end

	initial begin
		seed = 61037;
		fails = 0;
		num_checks = 0;
		bcnt = 0;
		rst_b = 1'b0;
		wp_i = 1'b0;
		strap = 3'h0;
		foreach (mem[i]) mem[i] = `SEIS_ERASED;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys) rst_b = 1'b1;
		repeat (6) @(negedge clk_sys);
		chk(sda_oe, 0);
		chk(prog_busy, 0);
		chk(sda_o, 0);
		ptr = 0;
		rd_seq(2);
		for (int t = 0; t < 4; t++) begin
			@(negedge clk_sys);
			strap = 3'($random(seed));
			// each single wrong strap bit must make the slave refuse the address
			for (int k = 0; k < 3; k++) begin
				sel(1'b0, strap ^ (3'h1 << k), ack);
				i_mst.stop();
				chk(ack, 1);
			end
			a = (t == 3) ? 16'h3fe5 : 16'($random(seed));
			n = (t == 1) ? 34 : (t == 3) ? 32 : 1 + t;
			w = (t == 2);
			i_mst.lo_ext = (t == 1) ? 150 : 0;
			@(negedge clk_sys) wp_i = w;
			wr(n, w);
			@(negedge clk_sys) wp_i = 1'b0;
			setup_addr(a);
			rd_seq(33);
			rd_seq(1);
		end
		conclude();
	end
endmodule
